/* dpw_ctrl.sv */
/*
  Wiper control: serial frame receiver, instruction decoder, wiper
  register, nonvolatile store model, preset and write protect.
  Assumes host is SPI mode 0 (sample on rising clock), all pins async.
*/
`default_nettype none
module dpw_ctrl
  import dpw_pkg::*;
#(
  parameter int unsigned STORE_CNT = dpw_pkg::STORE_CYCLES
) (
  input  wire logic                       i_clk,          // 40 MHz clock
  input  wire logic                       i_rst_n,        // Sync reset
  input  wire logic                       i_sclk,         // Link clock pin
  input  wire logic                       i_cs_n,         // Chip select
  input  wire logic                       i_serial_in,    // Serial data in
  input  wire logic                       i_wp_n,         // Write protect
  input  wire logic                       i_preset_strobe_n, // Preset pin
  output logic [dpw_pkg::WIPER_BITS-1:0]  o_wiper,        // Wiper position
  output logic                            o_serial_out_o, // Drive level
  output logic                            o_serial_out_oe,// Pull-down enable
  output logic                            o_ready_o,      // Drive level
  output logic                            o_ready_oe,     // Pull-down enable
  output logic                            o_busy          // Store running
);
  import dpw_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_STORE, ST_DONE} dpw_state_t;

  logic sclk_rise;
  logic cs_s, cs_rise, cs_fall;
  logic din_s, wp_s, preset_s, preset_rise;

  // Every pin passes two flops before use
  dpw_sync u_sclk (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_sclk),
    .o_level (),
    .o_rise  (sclk_rise),
    .o_fall  ()
  );

  dpw_sync u_cs (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_cs_n),
    .o_level (cs_s),
    .o_rise  (cs_rise),
    .o_fall  (cs_fall)
  );

  dpw_sync u_din (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_serial_in),
    .o_level (din_s),
    .o_rise  (),
    .o_fall  ()
  );

  dpw_sync u_wp (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_wp_n),
    .o_level (wp_s),
    .o_rise  (),
    .o_fall  ()
  );

  dpw_sync u_preset (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_preset_strobe_n),
    .o_level (preset_s),
    .o_rise  (preset_rise),
    .o_fall  ()
  );

  logic [FRAME_BITS-1:0] shift_in;
  logic [FRAME_BITS-1:0] shift_out;
  logic [FRAME_BITS-1:0] last_word;
  logic [4:0]            bit_cnt;
  logic [5:0]            total_cnt;
  logic                  have_bits;
  logic [WIPER_BITS-1:0] wiper;
  logic [NV_BITS-1:0]    nv_mem [NV_SLOTS];
  logic [NV_BITS-1:0]    nv_wdata;
  logic [3:0]            nv_waddr;
  dpw_state_t            state;
  logic [31:0]           tmr;
  logic                  cmd_valid;
  logic                  repeat_ok;
  logic [FRAME_BITS-1:0] exec_word;
  dpw_op_t               op;
  logic [3:0]            addr;
  logic                  nibble_ok;
  logic                  restore_done;
  logic                  locked;

  // Saturating adjustments
  function automatic logic [WIPER_BITS-1:0] adjust(
    input dpw_op_t               f_op,
    input logic [WIPER_BITS-1:0] f_w
  );
    logic [WIPER_BITS-1:0] r;
    r = f_w;
    case (f_op)
      OP_HALVE_A, OP_HALVE_B: r = f_w >> 1;
      OP_DEC_A, OP_DEC_B:
        r = (f_w == WIPER_MIN) ? WIPER_MIN : f_w - 10'h001;
      OP_DOUBLE_A, OP_DOUBLE_B:
        r = f_w[WIPER_BITS-1] ? WIPER_MAX : (f_w << 1);
      OP_INC_A, OP_INC_B:
        r = (f_w == WIPER_MAX) ? WIPER_MAX : f_w + 10'h001;
      default: r = f_w;
    endcase
    return r;
  endfunction : adjust

  function automatic logic is_step(input dpw_op_t f_op);
    logic s;
    s = (f_op inside {OP_HALVE_A, OP_HALVE_B, OP_DEC_A, OP_DEC_B,
                      OP_DOUBLE_A, OP_DOUBLE_B, OP_INC_A, OP_INC_B});
    return s;
  endfunction : is_step

  // Serial side frozen while a store runs
  assign locked    = (state == ST_STORE);
  assign nibble_ok = (total_cnt[1:0] & NIBBLE_MASK) == 2'h0;
  // Empty strobe repeats the previous command only when that command was an adjustment
  assign exec_word = have_bits ? shift_in : last_word;
  assign op        = dpw_op_t'(exec_word[CMD_MSB:CMD_LSB]);
  assign addr      = exec_word[ADDR_MSB:ADDR_LSB];
  assign cmd_valid = cs_rise && !locked &&
                     (have_bits ? (nibble_ok && bit_cnt == 5'd0)
                                : repeat_ok);

  // Frame receiver
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      shift_in  <= '0;
      bit_cnt   <= '0;
      total_cnt <= '0;
      have_bits <= 1'b0;
    end
    else if (cs_fall || cs_s)
    begin
      bit_cnt   <= '0;
      total_cnt <= '0;
      if (cs_fall)
        have_bits <= 1'b0;
    end
    else if (sclk_rise && !locked)
    begin
      shift_in  <= {shift_in[FRAME_BITS-2:0], din_s};
      have_bits <= 1'b1;
      total_cnt <= total_cnt + 6'd1;
      bit_cnt   <= (bit_cnt == 5'(FRAME_BITS - 1)) ? 5'd0
                   : bit_cnt + 5'd1;
    end
  end

  // Outgoing word: previous frame, or readback
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      shift_out <= '0;
      last_word <= '0;
      repeat_ok <= 1'b0;
    end
    else if (cmd_valid)
    begin
      if (have_bits)
        last_word <= shift_in;
      repeat_ok <= is_step(op);
      case (op)
        OP_READ_NV:
          shift_out <= {exec_word[CMD_MSB:ADDR_LSB], nv_mem[addr]};
        OP_READ_WIP:
          shift_out <= {exec_word[CMD_MSB:ADDR_LSB], 6'h00, wiper};
        default: shift_out <= exec_word;
      endcase
    end
    else if (!cs_s && sclk_rise && !locked)
      shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
  end

  // Open drain serial output, MSB presented while clock is low
  assign o_serial_out_o  = 1'b0;
  assign o_serial_out_oe = !cs_s && !shift_out[FRAME_BITS-1];

  // Wiper register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      wiper <= WIPER_MID;
    else if (!preset_s)
      wiper <= WIPER_MID;
    else if (preset_rise)
      wiper <= nv_mem[ADDR_WIPER][WIPER_BITS-1:0];
    else if (restore_done)
      wiper <= nv_mem[ADDR_WIPER][WIPER_BITS-1:0];
    else if (cmd_valid)
    begin
      case (op)
        OP_RESTORE, OP_RELOAD:
          wiper <= nv_mem[ADDR_WIPER][WIPER_BITS-1:0];
        OP_WRITE:
          if (wp_s && addr == ADDR_WIPER)
            wiper <= exec_word[WIPER_BITS-1:0];
        default:
          if (wp_s && is_step(op))
            wiper <= adjust(op, wiper);
      endcase
    end
  end
  assign o_wiper = wiper;

  // Power-on refresh one cycle after reset release
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      restore_done <= 1'b1;
    else
      restore_done <= 1'b0;
  end

  // Nonvolatile store contents
  genvar g;
  generate
    for (g = 0; g < NV_SLOTS; g++)
    begin : g_nv
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
          nv_mem[g] <= (g == 0) ? NV_MID : '0;
        else if (state == ST_STORE && tmr == '0 && nv_waddr == 4'(g))
          nv_mem[g] <= nv_wdata;
      end
    end
  endgenerate

  // Store sequencer and completion flag
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state    <= ST_IDLE;
      tmr      <= '0;
      nv_wdata <= '0;
      nv_waddr <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (preset_rise)
          begin
            state <= ST_DONE;
            tmr   <= 32'(DONE_CYCLES - 1);
          end
          else if (cmd_valid)
          begin
            case (op)
              // Stores refused while write protect is low
              OP_STORE:
                if (wp_s)
                begin
                  nv_waddr <= ADDR_WIPER;
                  nv_wdata <= {6'h00, wiper};
                  state    <= ST_STORE;
                  tmr      <= 32'(STORE_CNT - 1);
                end
              OP_STORE_AT:
                if (wp_s)
                begin
                  nv_waddr <= addr;
                  nv_wdata <= (addr == ADDR_WIPER)
                              ? {6'h00, wiper}
                              : exec_word[NV_BITS-1:0];
                  state    <= ST_STORE;
                  tmr      <= 32'(STORE_CNT - 1);
                end
              OP_RELOAD, OP_READ_NV, OP_READ_WIP:
              begin
                state <= ST_DONE;
                tmr   <= 32'(DONE_CYCLES - 1);
              end
              default: state <= ST_IDLE;
            endcase
          end
        ST_STORE:
          if (tmr == '0)
          begin
            state <= ST_DONE;
            tmr   <= 32'(DONE_CYCLES - 1);
          end
          else
            tmr <= tmr - 32'd1;
        ST_DONE:
          if (tmr == '0)
            state <= ST_IDLE;
          else
            tmr <= tmr - 32'd1;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Completion flag: pulled low during the done pulse
  assign o_ready_o  = 1'b0;
  assign o_ready_oe = (state == ST_DONE);
  assign o_busy     = locked;
endmodule : dpw_ctrl
`default_nettype wire

/* dpw_pkg.sv */
/*
  Shared constants for the wiper control block: frame layout, instruction
  codes, wiper codes and store timing.
  Assumes a 40 MHz system clock.
*/
`default_nettype none
package dpw_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned WIPER_BITS   = 10;
  localparam int unsigned NV_BITS      = 16;
  localparam int unsigned CMD_MSB      = 23;
  localparam int unsigned CMD_LSB      = 20;
  localparam int unsigned ADDR_MSB     = 19;
  localparam int unsigned ADDR_LSB     = 16;
  localparam int unsigned NV_SLOTS     = 16;
  localparam int unsigned STORE_MS     = 25;
  localparam int unsigned STORE_CYCLES = CLK_HZ / 1000 * STORE_MS;
  localparam int unsigned DONE_CYCLES  = 4;
  localparam logic [9:0]  WIPER_MID    = 10'h200;
  localparam logic [9:0]  WIPER_MAX    = 10'h3ff;
  localparam logic [9:0]  WIPER_MIN    = 10'h000;
  localparam logic [15:0] NV_MID       = 16'h0200;
  localparam logic [3:0]  ADDR_WIPER   = 4'h0;
  localparam logic [1:0]  NIBBLE_MASK  = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_RESTORE  = 4'h1,
    OP_STORE    = 4'h2,
    OP_STORE_AT = 4'h3,
    OP_HALVE_A  = 4'h4,
    OP_HALVE_B  = 4'h5,
    OP_DEC_A    = 4'h6,
    OP_DEC_B    = 4'h7,
    OP_RELOAD   = 4'h8,
    OP_READ_NV  = 4'h9,
    OP_READ_WIP = 4'ha,
    OP_WRITE    = 4'hb,
    OP_DOUBLE_A = 4'hc,
    OP_DOUBLE_B = 4'hd,
    OP_INC_A    = 4'he,
    OP_INC_B    = 4'hf
  } dpw_op_t;
endpackage : dpw_pkg
`default_nettype wire

/* dpw_sync.sv */
/*
  Two-flop synchroniser with edge detection on the synchronised level.
  Assumes the input is asynchronous to i_clk.
*/
`default_nettype none
module dpw_sync (
  input  wire logic i_clk,   // System clock
  input  wire logic i_rst_n, // Sync reset, active low
  input  wire logic i_async, // Raw pin
  output logic      o_level, // Synchronised level
  output logic      o_rise,  // One-cycle pulse on rise
  output logic      o_fall   // One-cycle pulse on fall
);
  logic meta;
  logic prev;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta    <= 1'b1;
      o_level <= 1'b1;
      prev    <= 1'b1;
    end
    else
    begin
      meta    <= i_async;
      o_level <= meta;
      prev    <= o_level;
    end
  end

  assign o_rise = o_level & ~prev;
  assign o_fall = ~o_level & prev;
endmodule : dpw_sync
`default_nettype wire

/* dpw_ctrl_sva.sv */
/*
  Checker for the wiper control block, bound to dpw_ctrl.
  Assumes a 2-flop input synchroniser and a registered wiper output.
*/
`default_nettype none
module dpw_ctrl_sva
  import dpw_pkg::*;
#(
  parameter int unsigned STORE_CNT = dpw_pkg::STORE_CYCLES
) (
  input wire logic                      i_clk,             // Clock
  input wire logic                      i_rst_n,           // Reset
  input wire logic                      i_sclk,            // Link clock
  input wire logic                      i_cs_n,            // Chip select
  input wire logic                      i_serial_in,       // Data in
  input wire logic                      i_wp_n,            // Write protect
  input wire logic                      i_preset_strobe_n, // Preset pin
  input wire logic [dpw_pkg::WIPER_BITS-1:0] o_wiper,      // Wiper
  input wire logic                      o_serial_out_o,    // Drive level
  input wire logic                      o_serial_out_oe,   // Drive enable
  input wire logic                      o_ready_o,         // Drive level
  input wire logic                      o_ready_oe,        // Drive enable
  input wire logic                      o_busy             // Store running
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt;

  // Length of the running store
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !o_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_done_pulse;
    o_ready_oe [*4] ##1 !o_ready_oe;
  endsequence
  sequence s_cs_idle;
    i_cs_n [*5];
  endsequence

  a_serout_off_idle: assert property (s_cs_idle |-> !o_serial_out_oe)
    else $error("serial out driven while deselected");
  a_od_levels: assert property (!o_serial_out_o && !o_ready_o)
    else $error("open drain level not low");
  a_ready_width: assert property ($rose(o_ready_oe) |-> s_done_pulse)
    else $error("done pulse width wrong");
  a_store_done: assert property ($fell(o_busy) |->
    ##[0:2] $rose(o_ready_oe))
    else $error("no done pulse after store");
  a_store_length: assert property ($fell(o_busy) |->
    busy_cnt >= STORE_CNT && busy_cnt <= STORE_CNT + 1)
    else $error("store length wrong");
  a_store_lock: assert property (o_busy && $past(o_busy) && i_preset_strobe_n
    |-> $stable(o_wiper))
    else $error("wiper moved during store");
  a_preset_mid: assert property (!i_preset_strobe_n [*5]
    |-> o_wiper == WIPER_MID)
    else $error("wiper not midscale under preset");
  a_frame_hold: assert property ((!i_cs_n && i_preset_strobe_n) [*8]
    |-> $stable(o_wiper))
    else $error("wiper moved inside a frame");
endmodule : dpw_ctrl_sva
`default_nettype wire

/* dpw_host_model.sv */
/*
  Host model: link master sending 24-bit frames, link clock idle low.
  Assumes the serial out line has a pull-up, so its level is ~oe.
*/
`default_nettype none
module dpw_host_model (
  output logic      o_sclk,   // Link clock
  output logic      o_cs_n,   // Chip select
  output logic      o_serial_in,    // Serial data to device
  input  wire logic i_serial_out_oe // Device pulls line low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime HALF = 100ns;

  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_serial_in = 1'b0;
  end

  task automatic frame(input logic [23:0] w, output logic [23:0] r);
    #7;
    o_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      o_serial_in = w[i];
      #HALF;
      r[i] = ~i_serial_out_oe;
      o_sclk = 1'b1;
      #HALF;
      o_sclk = 1'b0;
    end
    #HALF;
    o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in;
  endtask : frame

  // Frame cut to the first n bits
  task automatic short_frame(input logic [23:0] w, input int n);
    #7;
    o_cs_n = 1'b0;
    for (int i = 23; i > 23 - n; i--)
    begin
      o_serial_in = w[i];
      #HALF;
      o_sclk = 1'b1;
      #HALF;
      o_sclk = 1'b0;
    end
    #HALF;
    o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in;
  endtask : short_frame

  task automatic strobe();
    o_cs_n = 1'b0;
    #HALF;
    o_cs_n = 1'b1;
  endtask : strobe
endmodule : dpw_host_model
`default_nettype wire

/* tb_digipot_wiper_nv_control.sv */
/*
  Testbench for the wiper control block with a reference model.
  Assumes dpw_ctrl, dpw_host_model and the checker are compiled first.
*/
`default_nettype none
bind dpw_ctrl dpw_ctrl_sva #(.STORE_CNT(STORE_CNT)) u_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_serial_in(i_serial_in), .i_wp_n(i_wp_n),
  .i_preset_strobe_n(i_preset_strobe_n), .o_wiper(o_wiper),
  .o_serial_out_o(o_serial_out_o), .o_serial_out_oe(o_serial_out_oe),
  .o_ready_o(o_ready_o), .o_ready_oe(o_ready_oe), .o_busy(o_busy));

module tb_digipot_wiper_nv_control;
  import dpw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 400;
  logic        clk = 0, rst_n = 0, wp_n = 1, preset_n = 1;
  logic        sclk, cs_n, ser_in, ser_out_o, ser_out_oe;
  logic        rdy_o, rdy_oe, busy, seen;
  logic [9:0]  wiper, mw;
  logic [15:0] nv [16];
  logic [23:0] prev, r;
  logic [3:0]  lstep;
  logic        ser_out_ok = 0;
  int          err_total = 0, n_compared = 0, cyc = 0;
  logic [3:0]  steps [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};

  dpw_ctrl #(.STORE_CNT(SC)) dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(ser_in), .i_wp_n(wp_n),
    .i_preset_strobe_n(preset_n), .o_wiper(wiper),
    .o_serial_out_o(ser_out_o), .o_serial_out_oe(ser_out_oe),
    .o_ready_o(rdy_o), .o_ready_oe(rdy_oe), .o_busy(busy));
  dpw_host_model host (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_serial_in(ser_in), .i_serial_out_oe(ser_out_oe));

  initial
    forever #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic [23:0] seen_v, input logic [23:0] exp);
    n_compared++;
    if (seen_v !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen_v, exp);
    end
  endtask : check

  function automatic logic [9:0] adj(input logic [3:0] c, input logic [9:0] v);
    case (c)
      4'h4, 4'h5: return v >> 1;
      4'h6, 4'h7: return (v == 10'h0) ? v : v - 10'h1;
      4'hc, 4'hd: return (v >= 10'h200) ? 10'h3ff : {v[8:0], 1'b0};
      default: return (v == 10'h3ff) ? v : v + 10'h1;
    endcase
  endfunction : adj

  task automatic send(input logic [23:0] w);
    logic [3:0] c;
    logic [3:0] a;
    c = w[23:20];
    a = w[19:16];
    host.frame(w, r);
    if (ser_out_ok)
      check(r, prev);
    ser_out_ok = 1'b1;
    seen = 1'b0;
    repeat (20) @(negedge clk) seen |= rdy_oe;
    case (c)
      4'h1, 4'h8: mw = nv[0][9:0];
      4'h2: if (wp_n) nv[0] = {6'h0, mw};
      4'h3: if (wp_n) nv[a] = (a == 4'h0) ? {6'h0, mw} : w[15:0];
      4'hb: if (wp_n && a == 4'h0) mw = w[9:0];
      4'h0, 4'h9, 4'ha: ;
      default:
        if (wp_n)
        begin
          lstep = c;
          mw = adj(c, mw);
        end
    endcase
    prev = (c == 4'h9) ? {w[23:16], nv[a]} :
      (c == 4'ha) ? {w[23:16], 6'h0, mw} : w;
    check(wiper, mw);
    check(seen, c == 4'h8 || c == 4'h9 || c == 4'ha);
    if ((c == 4'h2 || c == 4'h3) && wp_n)
    begin
      check(busy, 1'b1);
      host.frame(24'hb003ff, r);
      for (int k = 0; k < 600 && busy === 1'b1; k++) @(negedge clk);
      seen = 1'b0;
      repeat (6) @(negedge clk) seen |= rdy_oe;
      check(seen, 1'b1);
      check(wiper, mw);
    end
    else
      check(busy, 1'b0);
  endtask : send

  initial
  begin
    void'($urandom(80187));
    foreach (nv[i]) nv[i] = 16'h0;
    nv[0] = NV_MID;
    mw = WIPER_MID;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    check(wiper, 10'h200);
    send(24'hb00100);
    send(24'h200000);
    send(24'h31a5c3);
    send(24'h910000);
    send(24'ha00000);
    send(24'h000000);
    foreach (steps[i])
    begin
      send({steps[i], 20'h0});
      host.strobe();
      repeat (20) @(negedge clk);
      mw = adj(lstep, mw);
      check(wiper, mw);
      ser_out_ok = 1'b0;
    end
    send(24'hb003ff);
    send(24'he00000);
    send(24'hb00000);
    send(24'h600000);
    send(24'hb00300);
    send(24'hc00000);
    send(24'hb10055);
    send(24'h100000);
    send(24'hb00010);
    send(24'h800000);
    wp_n = 1'b0;
    send(24'hb00077);
    send(24'he00000);
    send(24'h200000);
    send(24'h100000);
    send(24'h000000);
    wp_n = 1'b1;
    send(24'hb00123);
    preset_n = 1'b0;
    repeat (10) @(negedge clk);
    check(wiper, 10'h200);
    preset_n = 1'b1;
    seen = 1'b0;
    repeat (10) @(negedge clk) seen |= rdy_oe;
    check(seen, 1'b1);
    mw = nv[0][9:0];
    check(wiper, mw);
    host.short_frame(24'hb00155, 20);
    repeat (20) @(negedge clk);
    check(wiper, mw);
    ser_out_ok = 1'b0;
    repeat (12)
    begin
      send({4'hb, 4'h0, 6'h0, 10'($urandom)});
      send({steps[$urandom_range(7)], 20'h0});
    end
    summarize();
  end
endmodule : tb_digipot_wiper_nv_control
`default_nettype wire
